// >>> hdl/cit_pkg.sv
package cit_pkg;

    // clock and derived timing
    localparam int unsigned CLK_HZ        = 25000000;
    localparam int unsigned VCOUNT_US     = 32;
    localparam int unsigned DUMP_FAST_HZ  = 3300000;
    localparam int unsigned DUMP_SLOW_HZ  = 2000000;
    localparam int unsigned VSTEP_CYC_I   = (VCOUNT_US * (CLK_HZ / 1000000));
    localparam logic [9:0]  VSTEP_LAST    = 10'(VSTEP_CYC_I - 1);
    localparam logic [3:0]  DUMP_FAST_CYC = 4'(CLK_HZ / DUMP_FAST_HZ);
    localparam logic [3:0]  DUMP_SLOW_CYC = 4'(CLK_HZ / DUMP_SLOW_HZ);

    // vertical counter, one field of 625 counts
    localparam logic [9:0]  VCOUNT_LAST   = 10'h270;
    localparam logic [9:0]  VCOUNT_PRESET = 10'h010;
    localparam logic [9:0]  VD_LOW_END    = 10'h010;
    localparam logic [9:0]  DISP_FIRST    = 10'h030;
    localparam logic [9:0]  DISP_LAST     = 10'h26A;
    localparam logic [9:0]  VERTICAL_COUNT_DECODE_TEST_FIRST   = 10'h010;
    localparam logic [9:0]  VERTICAL_COUNT_DECODE_TEST_LAST    = 10'h02F;

    // burst lengths
    localparam logic [8:0]  FLUSH_PULSES  = 9'h12E;
    localparam logic [8:0]  READ_PULSES   = 9'h122;

    // register map
    localparam logic [7:0]  CTRL_ADDR     = 8'h00;
    localparam logic [7:0]  STATUS_ADDR   = 8'h04;
    localparam logic [7:0]  BURSTS_ADDR   = 8'h08;
    localparam int unsigned CTRL_RUN_BIT  = 0;
    localparam int unsigned CTRL_PRE_BIT  = 1;
    localparam logic        CTRL_RUN_RST  = 1'b1;
    localparam int unsigned ST_MODE_BIT   = 16;
    localparam int unsigned ST_VD_BIT     = 17;
    localparam int unsigned ST_BUSY_BIT   = 18;
    localparam int unsigned ST_PEND_BIT   = 19;

    typedef enum logic [1:0] {
        BST_IDLE,
        BST_WAIT_VD,
        BST_RUN
    } cit_burst_state_type;

endpackage

// >>> hdl/cit_timing.sv
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - dump clock 3.3 MHz high, 2 MHz low
// - low mode select enters variable integration
// - variable mode: only gate input steers transfers
// - each gate low pulse while drive is high gives 302 pulses; the code ignores a gate fall while a burst is still running
// - gate input high keeps sensor integrating
// - drive and gate both low starts readout
// - readout tied to vertical drive pulse
// - readout finishes within one field
// - display area shown on test output
// - decoded vertical count on test output; code drives it in variable mode only, forced low in normal mode
// - counter reset rising edge presets to 16
// - high mode select: 20 ms, drive gates internally
// - gate input gates image and storage clocks
// - gate low during drive low: 290 pulses later
module cit_timing
    import cit_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        exposure_mode_select,
    input  wire logic        parallel_transfer_gate_in,
    input  wire logic        dump_speed_select,
    input  wire logic        vertical_counter_reset,
    output logic             vertical_drive,
    output logic             image_area_gate_clock,
    output logic             storage_area_gate_clock,
    output logic             transfer_gate_clock,
    output logic             display_area_test_out,
    output logic             vertical_count_decode_test
);

    function automatic logic in_range(input logic [9:0] v, input logic [9:0] lo,
                                      input logic [9:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // pin synchronisers; stage 0 feeds only stage 1
    logic [3:0] pin_s0_q;
    logic [3:0] pin_s1_q;
    logic       vcr_prev_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s0_q   <= 4'hF;
            pin_s1_q   <= 4'hF;
            vcr_prev_q <= 1'b1;
        end
        else if (ce)
        begin
            pin_s0_q   <= {vertical_counter_reset, dump_speed_select,
                           parallel_transfer_gate_in, exposure_mode_select};
            pin_s1_q   <= pin_s0_q;
            vcr_prev_q <= pin_s1_q[3];
        end
    end

    logic mode_normal;
    logic gate_sync;
    logic dump_fast;
    logic vcr_rise;

    assign mode_normal = pin_s1_q[0];
    assign gate_sync   = pin_s1_q[1];
    assign dump_fast   = pin_s1_q[2];
    assign vcr_rise    = pin_s1_q[3] && !vcr_prev_q;

    // register bus state
    logic        run_q;
    logic        preset_q;
    logic [15:0] flush_cnt_q;
    logic [15:0] read_cnt_q;
    logic        wr_ctrl;
    logic        wr_bursts;

    assign wr_ctrl   = psel && penable && pwrite && (paddr == CTRL_ADDR);
    assign wr_bursts = psel && penable && pwrite && (paddr == BURSTS_ADDR);

    // vertical counter: 32 us per count, 625 counts per 20 ms field
    logic [9:0] vstep_q;
    logic [9:0] vcount_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vstep_q  <= 10'h000;
            vcount_q <= 10'h000;
        end
        else if (ce)
        begin
            if (vcr_rise || preset_q)
            begin
                vstep_q  <= 10'h000;
                vcount_q <= VCOUNT_PRESET;
            end
            else if (run_q)
            begin
                if (vstep_q == VSTEP_LAST)
                begin
                    vstep_q  <= 10'h000;
                    vcount_q <= (vcount_q == VCOUNT_LAST) ? 10'h000
                                                          : vcount_q + 10'h001;
                end
                else
                    vstep_q <= vstep_q + 10'h001;
            end
        end
    end

    logic vd_q;
    logic disp_q;
    logic vertical_count_decode_test_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vd_q    <= 1'b0;
            disp_q  <= 1'b0;
            vertical_count_decode_test_q <= 1'b0;
        end
        else if (ce)
        begin
            vd_q    <= (vcount_q >= VD_LOW_END);
            disp_q  <= in_range(vcount_q, DISP_FIRST, DISP_LAST);
            // decode forced low in normal mode
            vertical_count_decode_test_q <= !mode_normal && in_range(vcount_q, VERTICAL_COUNT_DECODE_TEST_FIRST, VERTICAL_COUNT_DECODE_TEST_LAST);
        end
    end

    assign vertical_drive             = vd_q;
    assign display_area_test_out      = disp_q;
    assign vertical_count_decode_test = vertical_count_decode_test_q;

    // effective transfer gate: drive in normal mode, pin otherwise
    logic gate_eff;
    logic gate_prev_q;
    logic gate_fall;

    assign gate_eff  = mode_normal ? vd_q : gate_sync;
    assign gate_fall = gate_prev_q && !gate_eff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            gate_prev_q <= 1'b0;  // drive is low in reset, so no false fall
        else if (ce)
            gate_prev_q <= gate_eff;
    end

    // burst engine; a gate fall during a running burst is ignored
    cit_burst_state_type bst_q;
    logic [8:0]          pulses_left_q;
    logic [3:0]          phase_q;
    logic                is_read_q;
    logic                pulse_q;
    logic                burst_done;
    logic [3:0]          period;

    assign period     = dump_fast ? DUMP_FAST_CYC : DUMP_SLOW_CYC;
    assign burst_done = (bst_q == BST_RUN) && (phase_q >= period - 4'h1)
                        && (pulses_left_q == 9'h001);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bst_q         <= BST_IDLE;
            pulses_left_q <= 9'h000;
            phase_q       <= 4'h0;
            is_read_q     <= 1'b0;
        end
        else if (ce)
        begin
            case (bst_q)
                BST_IDLE:
                begin
                    phase_q <= 4'h0;
                    if (gate_fall && vd_q)
                    begin
                        bst_q         <= BST_RUN;
                        pulses_left_q <= FLUSH_PULSES;
                        is_read_q     <= 1'b0;
                    end
                    else if (gate_fall)
                        bst_q <= BST_WAIT_VD;
                end
                BST_WAIT_VD:
                begin
                    phase_q <= 4'h0;
                    if (vd_q)
                    begin
                        bst_q         <= BST_RUN;
                        pulses_left_q <= READ_PULSES;
                        is_read_q     <= 1'b1;
                    end
                end
                BST_RUN:
                begin
                    // period may shrink mid pulse, so compare with >=
                    if (phase_q >= period - 4'h1)
                    begin
                        phase_q       <= 4'h0;
                        pulses_left_q <= pulses_left_q - 9'h001;
                        if (pulses_left_q == 9'h001)
                            bst_q <= BST_IDLE;
                    end
                    else
                        phase_q <= phase_q + 4'h1;
                end
                default:
                    bst_q <= BST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pulse_q <= 1'b0;
        else if (ce)
            pulse_q <= (bst_q == BST_RUN) && (phase_q < {1'b0, period[3:1]});
    end

    assign image_area_gate_clock   = pulse_q;
    assign storage_area_gate_clock = pulse_q;
    assign transfer_gate_clock     = pulse_q;

    // control register: run enable and one-shot preset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_q    <= CTRL_RUN_RST;
            preset_q <= 1'b0;
        end
        else if (ce)
        begin
            preset_q <= wr_ctrl && pwdata[CTRL_PRE_BIT];
            if (wr_ctrl)
                run_q <= pwdata[CTRL_RUN_BIT];
        end
    end

    // burst counters: write clears, a burst completing in the same cycle leaves its counter at 1
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flush_cnt_q <= 16'h0000;
            read_cnt_q  <= 16'h0000;
        end
        else if (ce)
        begin
            if (burst_done && !is_read_q)
                flush_cnt_q <= wr_bursts ? 16'h0001 : flush_cnt_q + 16'h0001;
            else if (wr_bursts)
                flush_cnt_q <= 16'h0000;
            if (burst_done && is_read_q)
                read_cnt_q <= wr_bursts ? 16'h0001 : read_cnt_q + 16'h0001;
            else if (wr_bursts)
                read_cnt_q <= 16'h0000;
        end
    end

    // read data captured in the setup cycle so the access phase needs no wait
    logic [31:0] rdata_q;
    logic        err_q;
    logic [31:0] status_word;

    always_comb
    begin
        status_word                = 32'h00000000;
        status_word[9:0]           = vcount_q;
        status_word[ST_MODE_BIT]   = !mode_normal;
        status_word[ST_VD_BIT]     = vd_q;
        status_word[ST_BUSY_BIT]   = (bst_q == BST_RUN);
        status_word[ST_PEND_BIT]   = (bst_q == BST_WAIT_VD);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= 32'h00000000;
            err_q   <= 1'b0;
        end
        else if (ce && psel && !penable)
        begin
            err_q   <= 1'b0;
            rdata_q <= 32'h00000000;
            case (paddr)
                CTRL_ADDR:   rdata_q <= {31'h0, run_q};
                STATUS_ADDR: rdata_q <= status_word;
                BURSTS_ADDR: rdata_q <= {read_cnt_q, flush_cnt_q};
                default:     err_q   <= 1'b1;
            endcase
        end
    end

    assign prdata  = rdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err_q;

endmodule // cit_timing

// >>> test/cit_exposure_model.sv
`timescale 1ns/1ps
module cit_exposure_model (
    input  wire logic clk,
    input  wire logic img,
    output logic      gate,
    output int        pulses
);
    logic img_q   = 1'b0;
    logic gate_q  = 1'b1;
    int   count_q = 0;

    assign gate   = gate_q;
    assign pulses = count_q;

    always @(posedge clk)
    begin
        img_q <= img;
        if (img && !img_q)
            count_q <= count_q + 1;
    end

    // caller pulses the gate with drive low as well as high
    task automatic gate_pulse(input int n);
        gate_q <= 1'b0;
        repeat (n) @(posedge clk);
        gate_q <= 1'b1;
    endtask
endmodule // cit_exposure_model

// >>> test/cit_timing_properties.sv
`timescale 1ns/1ps
module cit_timing_properties (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       exposure_mode_select,
    input wire logic       parallel_transfer_gate_in,
    input wire logic       dump_speed_select,
    input wire logic       vertical_counter_reset,
    input wire logic       vertical_drive,
    input wire logic       image_area_gate_clock,
    input wire logic       storage_area_gate_clock,
    input wire logic       transfer_gate_clock,
    input wire logic       display_area_test_out,
    input wire logic       vertical_count_decode_test
);
    wire logic       img = image_area_gate_clock;
    logic      [3:0] idle_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // 15 quiet cycles exceed the slowest dump period, so no burst runs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            idle_q <= 4'h0;
        else if (img)
            idle_q <= 4'h0;
        else if (idle_q != 4'hF)
            idle_q <= idle_q + 4'h1;
    end

    a_clocks_equal: assert property (
        storage_area_gate_clock == img && transfer_gate_clock == img)
        else $error("gate clocks differ");
    a_fast_width: assert property (
        $rose(img) && dump_speed_select && $past(dump_speed_select, 8) |-> img[*3] ##1 !img)
        else $error("fast dump high time wrong");
    a_slow_width: assert property (
        $rose(img) && !dump_speed_select && !$past(dump_speed_select, 8) |-> img[*6] ##1 !img)
        else $error("slow dump high time wrong");
    a_vertical_count_decode_test_normal: assert property (
        exposure_mode_select[*6] |-> !vertical_count_decode_test)
        else $error("count decode high in normal mode");
    a_vcr_preset: assert property (
        $rose(vertical_counter_reset) |-> ##[1:8] vertical_drive)
        else $error("counter reset did not preset");
    a_display_vd: assert property (
        !vertical_drive |-> !display_area_test_out)
        else $error("display area during drive low");
    a_burst_start: assert property (
        $fell(parallel_transfer_gate_in) && vertical_drive && !exposure_mode_select
        && !$past(exposure_mode_select, 6) && idle_q == 4'hF |-> ##[1:14] img)
        else $error("flush burst did not start");
    a_normal_ignore: assert property (
        exposure_mode_select[*6] ##0 ($fell(parallel_transfer_gate_in) && vertical_drive
        && $past(vertical_drive, 8) && idle_q == 4'hF) |-> (!img)[*8])
        else $error("gate pin acted in normal mode");
endmodule // cit_timing_properties

bind cit_timing cit_timing_properties chk (
    .clk                        (clk),
    .arst_n                     (arst_n),
    .exposure_mode_select       (exposure_mode_select),
    .parallel_transfer_gate_in  (parallel_transfer_gate_in),
    .dump_speed_select          (dump_speed_select),
    .vertical_counter_reset     (vertical_counter_reset),
    .vertical_drive             (vertical_drive),
    .image_area_gate_clock      (image_area_gate_clock),
    .storage_area_gate_clock    (storage_area_gate_clock),
    .transfer_gate_clock        (transfer_gate_clock),
    .display_area_test_out      (display_area_test_out),
    .vertical_count_decode_test (vertical_count_decode_test)
);

// >>> test/cit_timing_test.sv
`timescale 1ns/1ps
module cit_timing_test;
    import cit_pkg::*;
    logic        clk, arst_n, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        exposure_mode_select, parallel_transfer_gate_in, dump_speed_select;
    logic        vertical_counter_reset, vertical_drive, image_area_gate_clock;
    logic        storage_area_gate_clock, transfer_gate_clock;
    logic        display_area_test_out, vertical_count_decode_test;
    int          fail_count, tests_run, seed, base, pulses;

    cit_timing uut (
        .clk                        (clk),
        .arst_n                     (arst_n),
        .ce                         (ce),
        .psel                       (psel),
        .penable                    (penable),
        .pwrite                     (pwrite),
        .paddr                      (paddr),
        .pwdata                     (pwdata),
        .prdata                     (prdata),
        .pready                     (pready),
        .pslverr                    (pslverr),
        .exposure_mode_select       (exposure_mode_select),
        .parallel_transfer_gate_in  (parallel_transfer_gate_in),
        .dump_speed_select          (dump_speed_select),
        .vertical_counter_reset     (vertical_counter_reset),
        .vertical_drive             (vertical_drive),
        .image_area_gate_clock      (image_area_gate_clock),
        .storage_area_gate_clock    (storage_area_gate_clock),
        .transfer_gate_clock        (transfer_gate_clock),
        .display_area_test_out      (display_area_test_out),
        .vertical_count_decode_test (vertical_count_decode_test)
    );
    cit_exposure_model px (
        .clk    (clk),
        .img    (image_area_gate_clock),
        .gate   (parallel_transfer_gate_in),
        .pulses (pulses)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for ready
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        seed = 92996;
        fail_count = 0;
        tests_run = 0;
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        {exposure_mode_select, dump_speed_select, vertical_counter_reset} = 3'b110;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(1'b0, 8'h0C, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        exposure_mode_select <= 1'b0;
        repeat (8) @(posedge clk);
        base = pulses;
        px.gate_pulse(4);
        repeat (20) @(posedge clk);
        chk(pulses - base, 0);
        vertical_counter_reset <= 1'b1;
        repeat (10) @(posedge clk);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(rd & 32'h0002_03FF, 32'h0002_0010);
        repeat (290 * DUMP_FAST_CYC + 100) @(posedge clk);
        chk(pulses - base, 290);
        for (int i = 0; i < 2; i++)
        begin
            dump_speed_select <= (i == 0);
            repeat (8) @(posedge clk);
            base = pulses;
            px.gate_pulse(4);
            repeat (302 * (i == 0 ? DUMP_FAST_CYC : DUMP_SLOW_CYC) + 100) @(posedge clk);
            chk(pulses - base, 302);
        end
        base = pulses;
        repeat (4000) @(posedge clk);
        chk(pulses - base, 0);
        apb(1'b0, BURSTS_ADDR, 32'h0);
        chk(rd, 32'h0001_0002);
        apb(1'b1, BURSTS_ADDR, $random(seed));
        apb(1'b0, BURSTS_ADDR, 32'h0);
        chk(rd, 32'h0);
        // stop the count and preset it: more than one count step must pass with no advance
        apb(1'b1, CTRL_ADDR, 32'h0000_0002);
        repeat (900) @(posedge clk);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(rd & 32'h0002_03FF, 32'h0002_0010);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd, 32'h0);
        chk({vertical_drive, display_area_test_out, vertical_count_decode_test}, 3'b101);
        apb(1'b1, CTRL_ADDR, 32'h0000_0001);
        exposure_mode_select <= 1'b1;
        repeat (8) @(posedge clk);
        base = pulses;
        px.gate_pulse(4);
        repeat (300) @(posedge clk);
        chk(pulses - base, 0);
        tally_and_finish();
    end
endmodule // cit_timing_test
